// ===== design/fsb_signal_pkg.sv
// Constants shared by the lock and fatal-check-error ends of the shared system bus.
// Assumes one bus clock for both ends and software reaching the device end over APB.
// Function
// - Owner holds lock across whole locked sequence.
// - Priority agent waits for lock deasserted.
// - Locking agent keeps bus ownership throughout.
// - Fatal error line reports unrecoverable errors.
// - Every agent can drive fatal error line.
// - Fatal error assertion configurable, global enable.
// - Internal error asserts line and fault output.
// - Initiator asserts line on transaction error.
// - Any observing agent may assert line.
// - Fatal error line is wire-OR shared.
// - Assert and sample only on designated edges.
// - Bus reset releases all outputs within two clocks.
package fsb_signal_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] CFG_OFFSET = 8'h00;
  localparam logic [7:0] STATE_OFFSET = 8'h04;
  localparam logic [7:0] EVENT_OFFSET = 8'h08;
  localparam logic [7:0] EVENT_CLR_OFFSET = 8'h0C;
  localparam logic [7:0] EVENT_EN_OFFSET = 8'h10;
  localparam logic [7:0] LOCK_OFFSET = 8'h14;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CFG_GLOBAL_EN_BIT = 0;
  localparam int CFG_INTERNAL_EN_BIT = 1;
  localparam int CFG_INITIATOR_EN_BIT = 2;
  localparam int CFG_OBSERVER_EN_BIT = 3;
  localparam int CFG_WIDTH = 4;
  localparam int ST_LOCK_HELD_BIT = 0;
  localparam int ST_LOCK_LINE_BIT = 1;
  localparam int ST_FATAL_LINE_BIT = 2;
  localparam int ST_PRIORITY_REQ_BIT = 3;
  localparam int ST_FATAL_DRIVE_BIT = 4;
  localparam int ST_WIDTH = 5;
  localparam int EV_FATAL_SEEN_BIT = 0;
  localparam int EV_INTERNAL_BIT = 1;
  localparam int EV_TXN_ERR_BIT = 2;
  localparam int EV_LOCK_DONE_BIT = 3;
  localparam int EV_WIDTH = 4;
  localparam int LOCK_HOLD_BIT = 0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [CFG_WIDTH-1:0] CFG_RESET = 4'h0;
  localparam logic [EV_WIDTH-1:0] EV_RESET = 4'h0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  // Fatal error line phase period in bus clocks; drive at phase 0, sample at phase 1.
  localparam int EDGE_PERIOD = 2;
  localparam logic [0:0] DRIVE_PHASE = 1'h0;
  localparam logic [0:0] SAMPLE_PHASE = 1'h1;
  // Number of phase periods an asserted fatal error line is held.
  localparam int FATAL_HOLD_PERIODS = 2;
  // Bus clocks allowed to release outputs after bus reset is seen.
  localparam int RESET_RELEASE_CLOCKS = 2;

endpackage

// ===== design/fsb_signal_if.sv
// Shared system bus wires between the documented device end and the far agent end.
// Open-drain wires resolve here; every enable is active low, driving low when enabled.
`timescale 1ns/100ps
`default_nettype none
interface fsb_signal_if;

  logic devLockOut;
  logic devLockOeN;
  logic farLockOut;
  logic farLockOeN;
  logic lockLineN;
  logic devFatalOut;
  logic devFatalOeN;
  logic farFatalOut;
  logic farFatalOeN;
  logic fatal_check_error_n;
  logic priority_agent_request_n;
  logic busResetN;

  // Wire-OR: the line is low while any enabled driver pulls it low.
  assign lockLineN = (devLockOeN | devLockOut) & (farLockOeN | farLockOut);
  assign fatal_check_error_n = (devFatalOeN | devFatalOut) & (farFatalOeN | farFatalOut);

  modport device (
    output devLockOut, devLockOeN, devFatalOut, devFatalOeN,
    input lockLineN, fatal_check_error_n, priority_agent_request_n, busResetN
  );

  modport far (
    output farLockOut, farLockOeN, farFatalOut, farFatalOeN, priority_agent_request_n, busResetN,
    input lockLineN, fatal_check_error_n
  );

endinterface
`default_nettype wire

// ===== design/fsb_device_end.sv
// Device end: lock sequencing and fatal-check-error signalling with an APB register file.
// Assumes the far end drives bus reset and the priority request synchronous to core_clk.
`timescale 1ns/100ps
`default_nettype none
module fsb_device_end
  import fsb_signal_pkg::*;
#(
  parameter int HOLD_PERIODS = FATAL_HOLD_PERIODS
) (
  // Clock, reset and enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clkEn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Error sources inside the device
  input wire logic internalErr,
  input wire logic txnErr,
  input wire logic txnInitiator,
  output logic internal_fault_n,
  // Shared bus
  fsb_signal_if.device bus
);

  // ---------------------------------------------------------------
  // Bus interface
  // ---------------------------------------------------------------
  logic [CFG_WIDTH-1:0] cfg_q;
  logic [EV_WIDTH-1:0] event_q;
  logic [EV_WIDTH-1:0] eventEn_q;
  logic [EV_WIDTH-1:0] eventSet;
  logic lockHold_q;
  logic fatalDrive_q;
  logic fatalSeen_q;
  logic fatalPend_q;
  logic internalFault_q;
  logic [0:0] phase_q;
  logic [3:0] holdCnt_q;
  logic busReset_q;
  logic access;
  logic wrAccess;
  logic mapped;
  logic [31:0] rdData;
  logic [ST_WIDTH-1:0] stateBits;
  logic fatalCause;

  assign access = psel & penable & clkEn;
  assign wrAccess = access & pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr == CFG_OFFSET) || (paddr == STATE_OFFSET) || (paddr == EVENT_OFFSET) ||
                  (paddr == EVENT_CLR_OFFSET) || (paddr == EVENT_EN_OFFSET) || (paddr == LOCK_OFFSET);
  assign pslverr = psel & penable & ~mapped;
  assign irq = |(event_q & eventEn_q);

  always_comb begin
    stateBits = '0;
    stateBits[ST_LOCK_HELD_BIT] = lockHold_q;
    stateBits[ST_LOCK_LINE_BIT] = ~bus.lockLineN;
    stateBits[ST_FATAL_LINE_BIT] = fatalSeen_q;
    stateBits[ST_PRIORITY_REQ_BIT] = ~bus.priority_agent_request_n;
    stateBits[ST_FATAL_DRIVE_BIT] = fatalDrive_q;
  end

  always_comb begin
    rdData = 32'h0000_0000;
    unique case (paddr)
      CFG_OFFSET: rdData[CFG_WIDTH-1:0] = cfg_q;
      STATE_OFFSET: rdData[ST_WIDTH-1:0] = stateBits;
      EVENT_OFFSET: rdData[EV_WIDTH-1:0] = event_q;
      EVENT_EN_OFFSET: rdData[EV_WIDTH-1:0] = eventEn_q;
      LOCK_OFFSET: rdData[LOCK_HOLD_BIT] = lockHold_q;
      default: rdData = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite && clkEn) begin
      // Loaded in the setup cycle so the word stands at the access edge with no wait state.
      prdata <= rdData;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= CFG_RESET;
      eventEn_q <= EV_RESET;
    end else if (wrAccess && paddr == CFG_OFFSET) begin
      cfg_q <= pwdata[CFG_WIDTH-1:0];
    end else if (wrAccess && paddr == EVENT_EN_OFFSET) begin
      eventEn_q <= pwdata[EV_WIDTH-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Bus reset and phase
  // ---------------------------------------------------------------
  // Bus reset is registered once, so outputs release at the second clock edge at the latest.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busReset_q <= 1'b1;
    end else if (clkEn) begin
      busReset_q <= ~bus.busResetN;
    end
  end

  // Both ends restart their phase from bus reset, so they agree on the designated edges.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phase_q <= 1'h0;
    end else if (clkEn) begin
      if (busReset_q) begin
        phase_q <= 1'h0;
      end else if (phase_q == 1'(EDGE_PERIOD - 1)) begin
        phase_q <= 1'h0;
      end else begin
        phase_q <= phase_q + 1'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Lock sequence
  // ---------------------------------------------------------------
  // Software opens the sequence before its first transaction and closes it after its last.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lockHold_q <= 1'b0;
    end else if (clkEn) begin
      if (busReset_q) begin
        lockHold_q <= 1'b0;
      end else if (wrAccess && paddr == LOCK_OFFSET) begin
        lockHold_q <= pwdata[LOCK_HOLD_BIT];
      end
    end
  end

  // The lock is driven low only by the enable; it is never driven high.
  assign bus.devLockOut = 1'b0;
  assign bus.devLockOeN = ~lockHold_q;

  // ---------------------------------------------------------------
  // Fatal check error
  // ---------------------------------------------------------------
  assign fatalCause = cfg_q[CFG_GLOBAL_EN_BIT] & (
                      (internalErr & cfg_q[CFG_INTERNAL_EN_BIT]) |
                      (txnErr & txnInitiator & cfg_q[CFG_INITIATOR_EN_BIT]) |
                      (txnErr & cfg_q[CFG_OBSERVER_EN_BIT]));

  // A cause is parked until the next drive phase so the line only moves on designated edges.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fatalPend_q <= 1'b0;
      fatalDrive_q <= 1'b0;
      holdCnt_q <= 4'h0;
    end else if (clkEn) begin
      if (busReset_q) begin
        fatalPend_q <= 1'b0;
        fatalDrive_q <= 1'b0;
        holdCnt_q <= 4'h0;
      end else if (phase_q == DRIVE_PHASE) begin
        if (fatalPend_q || fatalCause) begin
          fatalPend_q <= 1'b0;
          fatalDrive_q <= 1'b1;
          holdCnt_q <= 4'(HOLD_PERIODS - 1);
        end else if (holdCnt_q != 4'h0) begin
          holdCnt_q <= holdCnt_q - 4'h1;
        end else begin
          fatalDrive_q <= 1'b0;
        end
      end else if (fatalCause) begin
        fatalPend_q <= 1'b1;
      end
    end
  end

  assign bus.devFatalOut = 1'b0;
  assign bus.devFatalOeN = ~fatalDrive_q;

  // Sampling happens on the phase opposite the drive phase, away from driver transitions.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fatalSeen_q <= 1'b0;
    end else if (clkEn && phase_q == SAMPLE_PHASE) begin
      fatalSeen_q <= ~bus.fatal_check_error_n;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      internalFault_q <= 1'b0;
    end else if (clkEn) begin
      if (busReset_q) begin
        internalFault_q <= 1'b0;
      end else if (internalErr) begin
        internalFault_q <= 1'b1;
      end else if (wrAccess && paddr == EVENT_CLR_OFFSET && pwdata[EV_INTERNAL_BIT]) begin
        internalFault_q <= 1'b0;
      end
    end
  end

  assign internal_fault_n = ~internalFault_q;

  // ---------------------------------------------------------------
  // Interrupt events
  // ---------------------------------------------------------------
  always_comb begin
    eventSet = '0;
    eventSet[EV_FATAL_SEEN_BIT] = clkEn & (phase_q == SAMPLE_PHASE) & ~bus.fatal_check_error_n & ~fatalSeen_q;
    eventSet[EV_INTERNAL_BIT] = clkEn & internalErr;
    eventSet[EV_TXN_ERR_BIT] = clkEn & txnErr;
    eventSet[EV_LOCK_DONE_BIT] = clkEn & lockHold_q & wrAccess & (paddr == LOCK_OFFSET) & ~pwdata[LOCK_HOLD_BIT];
  end

  // Set wins over a clear in the same cycle.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      event_q <= EV_RESET;
    end else if (clkEn) begin
      if (wrAccess && paddr == EVENT_CLR_OFFSET) begin
        event_q <= (event_q & ~pwdata[EV_WIDTH-1:0]) | eventSet;
      end else begin
        event_q <= event_q | eventSet;
      end
    end
  end

endmodule
`default_nettype wire

// ===== design/fsb_far_end.sv
// Far end: priority agent and chipset-side agent on the shared system bus.
// Assumes the device end counts drive and sample phases from the same bus reset.
`timescale 1ns/100ps
`default_nettype none
module fsb_far_end
  import fsb_signal_pkg::*;
#(
  parameter int HOLD_PERIODS = FATAL_HOLD_PERIODS
) (
  // Clock, reset and enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clkEn,
  // User side
  input wire logic resetReq,
  input wire logic wantBus,
  input wire logic lockReq,
  input wire logic errDetect,
  output logic busOwned,
  output logic fatalObserved,
  // Shared bus
  fsb_signal_if.far bus
);

  typedef enum logic [1:0] {
    ARB_IDLE = 2'b00,
    ARB_WAIT = 2'b01,
    ARB_OWN = 2'b10
  } arb_t;

  arb_t arb_q;
  logic reqDrive_q;
  logic lockDrive_q;
  logic fatalDrive_q;
  logic fatalPend_q;
  logic fatalSeen_q;
  logic resetOut_q;
  logic resetSeen_q;
  logic [0:0] phase_q;
  logic [3:0] holdCnt_q;

  // ---------------------------------------------------------------
  // Bus reset and phase
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      resetOut_q <= 1'b1;
      resetSeen_q <= 1'b1;
    end else if (clkEn) begin
      resetOut_q <= resetReq;
      resetSeen_q <= resetOut_q;
    end
  end

  assign bus.busResetN = ~resetOut_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phase_q <= 1'h0;
    end else if (clkEn) begin
      // The phase restarts one clock after bus reset, as the device end sees it, so both drive on one edge.
      if (resetSeen_q || phase_q == 1'(EDGE_PERIOD - 1)) begin
        phase_q <= 1'h0;
      end else begin
        phase_q <= phase_q + 1'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Priority arbitration
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      arb_q <= ARB_IDLE;
      reqDrive_q <= 1'b0;
      lockDrive_q <= 1'b0;
    end else if (clkEn) begin
      if (resetOut_q) begin
        arb_q <= ARB_IDLE;
        reqDrive_q <= 1'b0;
        lockDrive_q <= 1'b0;
      end else begin
        unique case (arb_q)
          ARB_IDLE: begin
            if (wantBus) begin
              arb_q <= ARB_WAIT;
              reqDrive_q <= 1'b1;
            end
          end
          ARB_WAIT: begin
            if (!wantBus) begin
              arb_q <= ARB_IDLE;
              reqDrive_q <= 1'b0;
            end else if (bus.lockLineN) begin
              arb_q <= ARB_OWN;
            end
          end
          ARB_OWN: begin
            lockDrive_q <= lockReq;
            if (!wantBus && !lockDrive_q) begin
              arb_q <= ARB_IDLE;
              reqDrive_q <= 1'b0;
              lockDrive_q <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  assign busOwned = (arb_q == ARB_OWN);
  assign bus.priority_agent_request_n = ~reqDrive_q;
  assign bus.farLockOut = 1'b0;
  assign bus.farLockOeN = ~lockDrive_q;

  // ---------------------------------------------------------------
  // Fatal check error
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fatalPend_q <= 1'b0;
      fatalDrive_q <= 1'b0;
      holdCnt_q <= 4'h0;
    end else if (clkEn) begin
      if (resetOut_q) begin
        fatalPend_q <= 1'b0;
        fatalDrive_q <= 1'b0;
        holdCnt_q <= 4'h0;
      end else if (phase_q == DRIVE_PHASE) begin
        if (fatalPend_q || errDetect) begin
          fatalPend_q <= 1'b0;
          fatalDrive_q <= 1'b1;
          holdCnt_q <= 4'(HOLD_PERIODS - 1);
        end else if (holdCnt_q != 4'h0) begin
          holdCnt_q <= holdCnt_q - 4'h1;
        end else begin
          fatalDrive_q <= 1'b0;
        end
      end else if (errDetect) begin
        fatalPend_q <= 1'b1;
      end
    end
  end

  assign bus.farFatalOut = 1'b0;
  assign bus.farFatalOeN = ~fatalDrive_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fatalSeen_q <= 1'b0;
    end else if (clkEn && phase_q == SAMPLE_PHASE) begin
      fatalSeen_q <= ~bus.fatal_check_error_n;
    end
  end

  assign fatalObserved = fatalSeen_q;

endmodule
`default_nettype wire

// ===== test/fsb_signal_sva.sv
// Checker for the shared lock and fatal-check-error wires between the two ends.
// Assumes one bus clock and the interface signals handed in by name.
`timescale 1ns/100ps
`default_nettype none
module fsb_signal_sva #(
  parameter int HOLD_PERIODS = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Shared wires
  input wire logic devLockOut,
  input wire logic devLockOeN,
  input wire logic farLockOut,
  input wire logic farLockOeN,
  input wire logic lockLineN,
  input wire logic devFatalOut,
  input wire logic devFatalOeN,
  input wire logic farFatalOut,
  input wire logic farFatalOeN,
  input wire logic fatal_check_error_n,
  input wire logic priority_agent_request_n,
  input wire logic busResetN
);
  logic [7:0] lowCnt_q;
  logic ph_q;
  logic phSet_q;
  logic phRef_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // ---------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) lowCnt_q <= 8'h00;
    else if (devFatalOeN) lowCnt_q <= 8'h00;
    else lowCnt_q <= lowCnt_q + 8'h01;
  end

  // The reference phase is relearnt after every bus reset, as both ends restart their phase there.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ph_q <= 1'b0;
      phSet_q <= 1'b0;
      phRef_q <= 1'b0;
    end else if (!busResetN) begin
      ph_q <= 1'b0;
      phSet_q <= 1'b0;
    end else begin
      ph_q <= !ph_q;
      if (!devFatalOeN && lowCnt_q == 8'h00 && !phSet_q) begin
        phSet_q <= 1'b1;
        phRef_q <= ph_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_lock_wire; (!devLockOeN || !farLockOeN) |-> !lockLineN; endproperty
  a_lock_wire: assert property (p_lock_wire) else $error("lock line idle while driven");
  property p_far_waits; (!devLockOeN && farLockOeN) |=> farLockOeN; endproperty
  a_far_waits: assert property (p_far_waits) else $error("far end locked over device lock");
  property p_fatal_wire; (!devFatalOeN || !farFatalOeN) |-> !fatal_check_error_n; endproperty
  a_fatal_wire: assert property (p_fatal_wire) else $error("fatal line idle while driven");
  property p_open_drain; !devLockOut && !farLockOut && !devFatalOut && !farFatalOut; endproperty
  a_open_drain: assert property (p_open_drain) else $error("a shared wire driven high");
  property p_fatal_hold;
    $rose(devFatalOeN) && $past(busResetN) && $past(busResetN, 2) |->
      int'(lowCnt_q) >= 2 * HOLD_PERIODS && !lowCnt_q[0];
  endproperty
  a_fatal_hold: assert property (p_fatal_hold) else $error("fatal drive length wrong");
  property p_fatal_phase; (!devFatalOeN && lowCnt_q == 8'h00 && phSet_q) |-> ph_q == phRef_q; endproperty
  a_fatal_phase: assert property (p_fatal_phase) else $error("fatal drive on wrong edge");
  property p_dev_release; !busResetN [*2] |=> devLockOeN && devFatalOeN; endproperty
  a_dev_release: assert property (p_dev_release) else $error("device holds wires in bus reset");
  property p_far_release; !busResetN [*2] |=> farLockOeN && farFatalOeN && priority_agent_request_n; endproperty
  a_far_release: assert property (p_far_release) else $error("far end holds wires in bus reset");
endmodule
`default_nettype wire

// ===== test/fsb_signal_tb.sv
// Self-checking bench: both bus ends face each other, software reaches the device over APB.
// Assumes the package constants and a 25 MHz bus clock.
`timescale 1ns/100ps
`default_nettype none
module fsb_signal_tb;
  import fsb_signal_pkg::*;
  logic core_clk, rstn, clkEn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic internalErr, txnErr, txnInitiator, internal_fault_n;
  logic resetReq, wantBus, lockReq, errDetect, busOwned, fatalObserved, farSeen, seen;
  logic [31:0] expQ[$];
  logic [3:0] cfgTab[4] = '{4'h5, 4'h5, 4'h9, 4'hE};
  logic initTab[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic expTab[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  int fails, tests_run;

  fsb_signal_if bus_if();
  fsb_device_end #(.HOLD_PERIODS(2)) i_fsb_device_end (.core_clk(core_clk), .rstn(rstn), .clkEn(clkEn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .internalErr(internalErr), .txnErr(txnErr),
    .txnInitiator(txnInitiator), .internal_fault_n(internal_fault_n), .bus(bus_if));
  fsb_far_end #(.HOLD_PERIODS(2)) i_fsb_far_end (.core_clk(core_clk), .rstn(rstn), .clkEn(clkEn),
    .resetReq(resetReq), .wantBus(wantBus), .lockReq(lockReq), .errDetect(errDetect),
    .busOwned(busOwned), .fatalObserved(fatalObserved), .bus(bus_if));
  fsb_signal_sva #(.HOLD_PERIODS(2)) i_fsb_signal_sva (.core_clk(core_clk), .rstn(rstn),
    .devLockOut(bus_if.devLockOut), .devLockOeN(bus_if.devLockOeN), .farLockOut(bus_if.farLockOut),
    .farLockOeN(bus_if.farLockOeN), .lockLineN(bus_if.lockLineN), .devFatalOut(bus_if.devFatalOut),
    .devFatalOeN(bus_if.devFatalOeN), .farFatalOut(bus_if.farFatalOut), .farFatalOeN(bus_if.farFatalOeN),
    .fatal_check_error_n(bus_if.fatal_check_error_n), .busResetN(bus_if.busResetN),
    .priority_agent_request_n(bus_if.priority_agent_request_n));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Entered just after a rising edge; a read notes its expected word before its access edge.
  task automatic apb(input int wr, input logic [7:0] a, input logic [31:0] d, input int errExp);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr[0];
    paddr <= a;
    pwdata <= d;
    if (wr == 0) expQ.push_back(d);
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    check(32'(pslverr), 32'(errExp));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  // Read data stands at the access edge, so it is taken there, with pready sampled high.
  always @(posedge core_clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      check(prdata, expQ.pop_front());
    end
  end

  task automatic watch(output logic low);
    low = 1'b0;
    farSeen = 1'b0;
    repeat (10) begin
      @(negedge core_clk);
      if (bus_if.fatal_check_error_n === 1'b0) low = 1'b1;
      if (fatalObserved === 1'b1) farSeen = 1'b1;
    end
    @(posedge core_clk);
  endtask

  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    {internalErr, txnErr, txnInitiator, resetReq, wantBus, lockReq, errDetect} = '0;
    clkEn = 1'b1;
    fails = 0;
    tests_run = 0;
    rnd = $urandom(8567);
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    apb(0, CFG_OFFSET, 32'h0, 0);
    rnd = $urandom() & 32'hF;
    apb(1, EVENT_EN_OFFSET, rnd, 0);
    apb(0, EVENT_EN_OFFSET, rnd, 0);
    apb(1, CFG_OFFSET, 32'hF, 0);
    apb(0, CFG_OFFSET, 32'hF, 0);
    apb(0, 8'h20, 32'h0, 1);
    apb(0, EVENT_CLR_OFFSET, 32'h0, 0);
    $display("Register test done");
    apb(1, CFG_OFFSET, 32'h0, 0);
    internalErr <= 1'b1;
    @(posedge core_clk);
    internalErr <= 1'b0;
    watch(seen);
    check(32'(seen), 32'h0);
    check(32'(farSeen), 32'h0);
    apb(1, EVENT_CLR_OFFSET, 32'hF, 0);
    apb(1, EVENT_EN_OFFSET, 32'hF, 0);
    apb(1, CFG_OFFSET, 32'h3, 0);
    internalErr <= 1'b1;
    @(posedge core_clk);
    internalErr <= 1'b0;
    watch(seen);
    check(32'(seen), 32'h1);
    check(32'(farSeen), 32'h1);
    check(32'(internal_fault_n), 32'h0);
    check(32'(irq), 32'h1);
    apb(0, EVENT_OFFSET, 32'h3, 0);
    apb(1, EVENT_CLR_OFFSET, 32'hF, 0);
    check(32'(irq), 32'h0);
    check(32'(internal_fault_n), 32'h1);
    $display("Internal error test done");
    for (int i = 0; i < 4; i++) begin
      apb(1, CFG_OFFSET, 32'(cfgTab[i]), 0);
      txnInitiator <= initTab[i];
      txnErr <= 1'b1;
      @(posedge core_clk);
      txnErr <= 1'b0;
      watch(seen);
      check(32'(seen), 32'(expTab[i]));
    end
    apb(1, EVENT_CLR_OFFSET, 32'hF, 0);
    errDetect <= 1'b1;
    @(posedge core_clk);
    errDetect <= 1'b0;
    watch(seen);
    check(32'(seen), 32'h1);
    apb(0, EVENT_OFFSET, 32'h1, 0);
    apb(1, EVENT_CLR_OFFSET, 32'hF, 0);
    $display("Transaction error test done");
    apb(1, LOCK_OFFSET, 32'h1, 0);
    check(32'(bus_if.lockLineN), 32'h0);
    wantBus <= 1'b1;
    repeat (10) @(posedge core_clk);
    check(32'(busOwned), 32'h0);
    check(32'(bus_if.priority_agent_request_n), 32'h0);
    apb(1, LOCK_OFFSET, 32'h0, 0);
    repeat (6) @(posedge core_clk);
    check(32'(busOwned), 32'h1);
    lockReq <= 1'b1;
    repeat (3) @(posedge core_clk);
    apb(0, STATE_OFFSET, 32'hA, 0);
    lockReq <= 1'b0;
    wantBus <= 1'b0;
    repeat (4) @(posedge core_clk);
    $display("Lock test done");
    apb(1, CFG_OFFSET, 32'h3, 0);
    apb(1, LOCK_OFFSET, 32'h1, 0);
    internalErr <= 1'b1;
    repeat (4) @(posedge core_clk);
    resetReq <= 1'b1;
    repeat (5) @(posedge core_clk);
    check(32'(bus_if.lockLineN), 32'h1);
    check(32'(bus_if.fatal_check_error_n), 32'h1);
    internalErr <= 1'b0;
    resetReq <= 1'b0;
    repeat (4) @(posedge core_clk);
    apb(0, LOCK_OFFSET, 32'h0, 0);
    clkEn <= 1'b0;
    apb(1, LOCK_OFFSET, 32'h1, 0);
    clkEn <= 1'b1;
    apb(0, LOCK_OFFSET, 32'h0, 0);
    $display("Bus reset test done");
    stop_test();
  end

  initial begin
    repeat (3000) @(posedge core_clk);
    fails++;
    stop_test();
  end
endmodule
`default_nettype wire
